// ### bench/crxf_asserts.sv
// Purpose: port checks of the receive flag block
// Assumes: zero-wait apb slave
// Notes:   shadows done and enable flags
`timescale 1ns/1ps
`default_nettype none
`include "crxf_consts.svh"
module crxf_asserts #(
   parameter int NBUF = 8
) (
   input wire logic            mclk_in,
   input wire logic            rstn_in,
   input wire logic            psel_in,
   input wire logic            penable_in,
   input wire logic            pwrite_in,
   input wire logic [11:0]     paddr_in,
   input wire logic [31:0]     pwdata_in,
   input wire logic [3:0]      pstrb_in,
   input wire logic            pready_out,
   input wire logic [31:0]     prdata_out,
   input wire logic            pslverr_out,
   input wire logic [NBUF-1:0] rx_store_in,
   input wire logic            rx_irq_out
);
   logic [NBUF-1:0] done_reg;
   logic [NBUF-1:0] en_reg;
   logic            wr;
   logic            wr_en;
   assign wr = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
   assign wr_en = wr && paddr_in == `CRXF_OFS_IRQ_EN;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         done_reg <= '0;
         en_reg <= '0;
      end else begin
         done_reg <= (done_reg & (wr && paddr_in == `CRXF_OFS_DONE ? pwdata_in[NBUF-1:0] : '1))
            | rx_store_in;
         if (wr_en)
            en_reg <= pwdata_in[NBUF-1:0];
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   setup_ready_a: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready");
   idle_ready_a: assert property (!psel_in |=> !pready_out) else $error("stray ready");
   err_ready_a: assert property (pslverr_out |-> pready_out) else $error("lone error");
   upper_zero_a: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
      else $error("upper bits set");
   irq_match_a: assert property (rx_irq_out == |(done_reg & en_reg))
      else $error("irq differs");
   store_irq_a: assert property (|(rx_store_in & en_reg) && !wr_en |=> rx_irq_out)
      else $error("no irq");
   irq_gate_a: assert property (en_reg == '0 && !wr_en |=> !rx_irq_out)
      else $error("masked irq");
   irq_hold_a: assert property (rx_irq_out && !wr |=> rx_irq_out)
      else $error("irq dropped");
   store_c: cover property (|(rx_store_in & en_reg));
   error_c: cover property (pslverr_out);
   irq_c: cover property ($rose(rx_irq_out));
endmodule
bind crxf_top crxf_asserts #(.NBUF(NBUF)) chk (.mclk_in, .rstn_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out,
   .rx_store_in, .rx_irq_out);
`default_nettype wire

// ### bench/crxf_can_node.sv
// Purpose: far-side frames and tx completions
// Assumes: one event per toggle of req_in
// Notes:   lag_in delays the event
`timescale 1ns/1ps
`default_nettype none
module crxf_can_node (
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   input  wire logic       req_in,
   input  wire logic [2:0] buf_in,
   input  wire logic [1:0] kind_in,
   input  wire logic [1:0] lag_in,
   output var  logic [7:0] store_out,
   output var  logic [7:0] remote_out,
   output var  logic [7:0] txd_out
);
   logic       req_reg;
   logic       act_reg;
   logic [1:0] cnt_reg;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {req_reg, act_reg, cnt_reg} <= '0;
         {store_out, remote_out, txd_out} <= '0;
      end else begin
         req_reg <= req_in;
         act_reg <= req_reg != req_in || (act_reg && cnt_reg != 2'h0);
         cnt_reg <= req_reg != req_in ? lag_in : cnt_reg - 2'h1;
         {store_out, remote_out, txd_out} <= '0;
         if (act_reg && cnt_reg == 2'h0) begin
            store_out[buf_in] <= kind_in != 2'h2;
            remote_out[buf_in] <= kind_in == 2'h1;
            txd_out[buf_in] <= kind_in == 2'h2;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench of the receive flag block
// Assumes: zero-wait apb slave
// Notes:   random traffic from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "crxf_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   logic        clk, rstn, psel, pen, pwr, rdy, err, rirq, eirq, req, qe;
   logic [11:0] addr;
   logic [31:0] wdat, rdat, q;
   logic [7:0]  st, rm, tx, de, re, oe, ee, d0, m;
   logic [2:0]  bsel;
   logic [1:0]  kind, lag;
   int          n_fail = 0, cmp_count = 0, cyc = 0, r;
   crxf_top dut (.mclk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdat), .pstrb_in(4'hF), .pready_out(rdy),
      .prdata_out(rdat), .pslverr_out(err), .rx_store_in(st), .rx_remote_in(rm),
      .tx_done_in(tx), .rx_irq_out(rirq), .evt_irq_out(eirq));
   crxf_can_node node (.mclk_in(clk), .rstn_in(rstn), .req_in(req), .buf_in(bsel),
      .kind_in(kind), .lag_in(lag), .store_out(st), .remote_out(rm), .txd_out(tx));
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      q = rdat;
      qe = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   // write of mask m to register r keeps only the ones
   function automatic logic [7:0] upd(input logic [7:0] f, input int s);
      return (r == s) ? f & m : f;
   endfunction
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      {rstn, psel, pen, pwr, req, addr, wdat, bsel, kind, lag, de, re, oe} = '0;
      void'($urandom(58));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rd(`CRXF_OFS_OVERRUN, 32'h0);
      for (int i = 0; i < 80; i++) begin
         ee = 8'($urandom);
         apb(1'b1, `CRXF_OFS_IRQ_EN, {24'h0, ee});
         bsel <= 3'($urandom);
         kind <= 2'($urandom_range(2));
         lag <= 2'($urandom);
         req <= ~req;
         r = $urandom_range(2);
         m = (i % 8 == 0) ? 8'h00 : 8'($urandom | $urandom);
         // lag 0 lands the event on the clearing write
         apb(1'b1, 12'(r * 4), {24'h0, m});
         repeat (4) @(posedge clk);
         d0 = de;
         de = upd(de, 0);
         re = upd(re, 1);
         oe = upd(oe, 2);
         if (kind == 2'h2)
            re[bsel] = 1'b0;
         else begin
            oe[bsel] |= (lag == 2'h0) ? d0[bsel] : de[bsel];
            de[bsel] = 1'b1;
            re[bsel] = kind[0];
         end
         rd(`CRXF_OFS_DONE, {24'h0, de});
         rd(`CRXF_OFS_REMOTE, {24'h0, re});
         rd(`CRXF_OFS_OVERRUN, {24'h0, oe});
         rd(`CRXF_OFS_STATUS, {24'h0, de & ee});
         `CHK(rirq, |(de & ee))
      end
      apb(1'b1, `CRXF_OFS_RMW_CTRL, 32'h1);
      for (r = 0; r < 3; r++)
         rd(12'(r * 4), 32'hFF);
      rd(`CRXF_OFS_IRQ_EN, {24'h0, ee});
      apb(1'b1, `CRXF_OFS_RMW_CTRL, 32'h0);
      rd(`CRXF_OFS_DONE, {24'h0, de});
      apb(1'b1, `CRXF_OFS_IRQ_ENA, 32'h8);
      rd(12'h0FC, 32'h0);
      `CHK(qe, 1'b1)
      repeat (2) @(posedge clk);
      `CHK(eirq, 1'b1)
      apb(1'b1, `CRXF_OFS_IRQ_ENA, 32'h0);
      repeat (2) @(posedge clk);
      `CHK(eirq, 1'b0)
      apb(1'b1, `CRXF_OFS_IRQ_CLR, 32'h8);
      apb(1'b0, `CRXF_OFS_IRQ_STAT, 32'h0);
      `CHK(q[3], 1'b0)
      complete_run();
   end
endmodule
`default_nettype wire

// ### rtl/crxf_consts.svh
// Purpose: offsets, reset values and field positions of the receive flag block
// Assumes: 32-bit apb data, byte addresses
// Notes:   definitions only
`ifndef CRXF_CONSTS_SVH
`define CRXF_CONSTS_SVH

`define CRXF_OFS_DONE      12'h000
`define CRXF_OFS_REMOTE    12'h004
`define CRXF_OFS_OVERRUN   12'h008
`define CRXF_OFS_IRQ_EN    12'h00C
`define CRXF_OFS_RMW_CTRL  12'h010
`define CRXF_OFS_STATUS    12'h014
`define CRXF_OFS_IRQ_STAT  12'h018
`define CRXF_OFS_IRQ_CLR   12'h01C
`define CRXF_OFS_IRQ_ENA   12'h020

`define CRXF_FLAGS_RST     8'h00
`define CRXF_RMW_BIT       0
`define CRXF_EVT_DONE      0
`define CRXF_EVT_OVERRUN   1
`define CRXF_EVT_REMOTE    2
`define CRXF_EVT_BADADDR   3
`define CRXF_EVT_W         4
`define CRXF_EVT_RST       4'h0

`endif

// ### rtl/crxf_flag_bit.sv
// Purpose: one sticky flag with hardware set and software write-0 clear
// Assumes: set_in and clr_in are single-cycle strobes
// Notes:   set wins over clear; hw_clr_in clears unless set is present
`timescale 1ns/1ps
`default_nettype none
module crxf_flag_bit (
   input  wire logic mclk_in,
   input  wire logic rstn_in,
   input  wire logic set_in,
   input  wire logic clr_in,
   input  wire logic hw_clr_in,
   output var  logic flag_out
);
   logic flag_next;

   always_comb begin
      flag_next = flag_out;
      if (clr_in || hw_clr_in) begin
         flag_next = 1'b0;
      end
      if (set_in) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flag_out <= 1'b0;
      end else begin
         flag_out <= flag_next;
      end
   end
endmodule
`default_nettype wire

// ### rtl/crxf_pkg.sv
// Purpose: types of the receive flag block
// Assumes: nothing
// Notes:   offsets live in crxf_consts.svh
package crxf_pkg;
   typedef enum logic [1:0] {
      CRXF_IDLE,
      CRXF_ACCESS
   } crxf_apb_state_t;
endpackage

// ### rtl/crxf_top.sv
// Overview of operation
// - full reception into buffer x sets its receive-done bit
// - writing 0 clears a receive-done bit; writing 1 leaves it
// - reception completion beats a simultaneous software clear of receive-done
// - receive-done set with enable 1 raises the reception interrupt
// - read-modify-write reads of the three flag registers return all ones
// - remote frame into buffer x sets its remote-frame-seen bit
// - writing 0 clears a remote-frame-seen bit; writing 1 does nothing
// - remote frame arrival beats a simultaneous software clear
// - data frame into buffer x clears its remote-frame-seen bit
// - transmit completion on buffer x clears its remote-frame-seen bit
// - storing into a buffer whose receive-done is 1 sets overrun
// - writing 0 clears an overrun bit; writing 1 leaves it
// - overrun beats a simultaneous software clear of overrun
// - each enable bit gates the reception interrupt of its buffer
//
// Purpose: receive status flags of an eight-buffer can controller, apb slave
// Assumes: event inputs are one-cycle strobes synchronous to mclk_in
// Notes:   zero-wait apb slave; rmw read mode chosen by a control bit
//          0x00 receive done flags, write 0 to clear
//          0x04 remote frame seen flags, write 0 to clear
//          0x08 receive overrun flags, write 0 to clear
//          0x0C receive interrupt enables
//          0x10 bit 0 makes the three flag registers read as all ones
//          0x14 receive done and enable, read only
//          0x18 block event status: done, overrun, remote, bad address
//          0x1C block event clear, write 1 to clear
//          0x20 block event enables
//          unmapped accesses answer with pslverr and read zero
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crxf_consts.svh"
module crxf_top #(
   parameter int NBUF = 8
) (
   input  wire logic            mclk_in,
   input  wire logic            rstn_in,
   input  wire logic            psel_in,
   input  wire logic            penable_in,
   input  wire logic            pwrite_in,
   input  wire logic [11:0]     paddr_in,
   input  wire logic [31:0]     pwdata_in,
   input  wire logic [3:0]      pstrb_in,
   output var  logic            pready_out,
   output var  logic [31:0]     prdata_out,
   output var  logic            pslverr_out,
   input  wire logic [NBUF-1:0] rx_store_in,
   input  wire logic [NBUF-1:0] rx_remote_in,
   input  wire logic [NBUF-1:0] tx_done_in,
   output var  logic            rx_irq_out,
   output var  logic            evt_irq_out
);
   logic [NBUF-1:0] done_flags;
   logic [NBUF-1:0] remote_flags;
   logic [NBUF-1:0] overrun_flags;
   logic [NBUF-1:0] done_clr;
   logic [NBUF-1:0] remote_clr;
   logic [NBUF-1:0] overrun_clr;
   logic [NBUF-1:0] overrun_set;
   logic [NBUF-1:0] remote_hw_clr;
   logic [NBUF-1:0] irq_en_reg;
   logic [NBUF-1:0] irq_en_next;
   logic            rmw_reg;
   logic            rmw_next;
   logic [`CRXF_EVT_W-1:0] evt_stat_reg;
   logic [`CRXF_EVT_W-1:0] evt_stat_next;
   logic [`CRXF_EVT_W-1:0] evt_en_reg;
   logic [`CRXF_EVT_W-1:0] evt_en_next;
   logic [`CRXF_EVT_W-1:0] evt_set;
   logic [`CRXF_EVT_W-1:0] evt_clr;
   crxf_pkg::crxf_apb_state_t state_reg;
   crxf_pkg::crxf_apb_state_t state_next;
   logic            pready_next;
   logic [31:0]     prdata_next;
   logic            pslverr_next;
   logic            rx_irq_next;
   logic            evt_irq_next;
   logic            wr_stb;
   logic            setup_ph;
   logic            addr_ok;
   logic [7:0]      wbyte;
   logic [31:0]     rdata_comb;
   logic            sel_done;
   logic            sel_remote;
   logic            sel_overrun;
   logic            sel_irq_en;
   logic            sel_rmw;
   logic            sel_irq_clr;
   logic            sel_irq_ena;

   // transfer taken in the access phase; answer registered at the setup edge
   assign wr_stb   = psel_in && penable_in && pwrite_in && pstrb_in[0];
   assign setup_ph = psel_in && !penable_in;
   assign wbyte    = pwdata_in[7:0];

   // one select per writable register
   assign sel_done    = paddr_in == `CRXF_OFS_DONE;
   assign sel_remote  = paddr_in == `CRXF_OFS_REMOTE;
   assign sel_overrun = paddr_in == `CRXF_OFS_OVERRUN;
   assign sel_irq_en  = paddr_in == `CRXF_OFS_IRQ_EN;
   assign sel_rmw     = paddr_in == `CRXF_OFS_RMW_CTRL;
   assign sel_irq_clr = paddr_in == `CRXF_OFS_IRQ_CLR;
   assign sel_irq_ena = paddr_in == `CRXF_OFS_IRQ_ENA;

   always_comb begin
      case (paddr_in)
         `CRXF_OFS_DONE, `CRXF_OFS_REMOTE, `CRXF_OFS_OVERRUN, `CRXF_OFS_IRQ_EN,
         `CRXF_OFS_RMW_CTRL, `CRXF_OFS_STATUS, `CRXF_OFS_IRQ_STAT,
         `CRXF_OFS_IRQ_CLR, `CRXF_OFS_IRQ_ENA: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // software clears: a 0 in the written byte clears, a 1 leaves the bit
   always_comb begin
      done_clr    = '0;
      remote_clr  = '0;
      overrun_clr = '0;
      if (wr_stb && sel_done) begin
         done_clr = ~wbyte[NBUF-1:0];
      end
      if (wr_stb && sel_remote) begin
         remote_clr = ~wbyte[NBUF-1:0];
      end
      if (wr_stb && sel_overrun) begin
         overrun_clr = ~wbyte[NBUF-1:0];
      end
   end

   // overrun looks at the done flag before this edge, so a store into a
   // buffer still marked done is caught even when software clears it now
   always_comb begin
      overrun_set   = rx_store_in & done_flags;
      // a data frame is a store without remote; transmit end also clears
      remote_hw_clr = (rx_store_in & ~rx_remote_in) | tx_done_in;
   end

   genvar g;
   generate
      for (g = 0; g < NBUF; g++) begin : g_buf
         // set inputs beat clears inside the flag cell
         crxf_flag_bit u_done (
            .mclk_in   (mclk_in),
            .rstn_in   (rstn_in),
            .set_in    (rx_store_in[g]),
            .clr_in    (done_clr[g]),
            .hw_clr_in (1'b0),
            .flag_out  (done_flags[g])
         );
         crxf_flag_bit u_remote (
            .mclk_in   (mclk_in),
            .rstn_in   (rstn_in),
            .set_in    (rx_remote_in[g]),
            .clr_in    (remote_clr[g]),
            .hw_clr_in (remote_hw_clr[g]),
            .flag_out  (remote_flags[g])
         );
         // an overrun caught on the clearing edge still ends set
         crxf_flag_bit u_overrun (
            .mclk_in   (mclk_in),
            .rstn_in   (rstn_in),
            .set_in    (overrun_set[g]),
            .clr_in    (overrun_clr[g]),
            .hw_clr_in (1'b0),
            .flag_out  (overrun_flags[g])
         );
      end
   endgenerate

   // software control registers
   always_comb begin
      irq_en_next = irq_en_reg;
      rmw_next    = rmw_reg;
      if (wr_stb && sel_irq_en) begin
         irq_en_next = wbyte[NBUF-1:0];
      end
      if (wr_stb && sel_rmw) begin
         rmw_next = wbyte[`CRXF_RMW_BIT];
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_en_reg <= `CRXF_FLAGS_RST;
         rmw_reg    <= 1'b0;
      end else begin
         irq_en_reg <= irq_en_next;
         rmw_reg    <= rmw_next;
      end
   end

   // block event status: sticky, write 1 to clear, a same-cycle event wins
   always_comb begin
      evt_en_next = evt_en_reg;
      evt_clr     = '0;
      evt_set     = '0;
      if (wr_stb && sel_irq_ena) begin
         evt_en_next = wbyte[`CRXF_EVT_W-1:0];
      end
      if (wr_stb && sel_irq_clr) begin
         evt_clr = wbyte[`CRXF_EVT_W-1:0];
      end
      evt_set[`CRXF_EVT_DONE]    = |rx_store_in;
      evt_set[`CRXF_EVT_OVERRUN] = |overrun_set;
      evt_set[`CRXF_EVT_REMOTE]  = |rx_remote_in;
      // an unmapped address is flagged in its access phase
      evt_set[`CRXF_EVT_BADADDR] = psel_in && penable_in && !addr_ok;
      evt_stat_next = (evt_stat_reg & ~evt_clr) | evt_set;
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         evt_stat_reg <= `CRXF_EVT_RST;
         evt_en_reg   <= `CRXF_EVT_RST;
      end else begin
         evt_stat_reg <= evt_stat_next;
         evt_en_reg   <= evt_en_next;
      end
   end

   // apb answer: zero wait states, error on unmapped address
   always_comb begin
      state_next   = state_reg;
      pready_next  = 1'b0;
      prdata_next  = '0;
      pslverr_next = 1'b0;
      case (state_reg)
         crxf_pkg::CRXF_IDLE: begin
            if (psel_in && !penable_in) begin
               state_next  = crxf_pkg::CRXF_ACCESS;
               pready_next = 1'b1;
               pslverr_next = 1'b0;
            end
         end
         crxf_pkg::CRXF_ACCESS: begin
            state_next = (psel_in && !penable_in) ? crxf_pkg::CRXF_ACCESS
                                                  : crxf_pkg::CRXF_IDLE;
            pready_next = psel_in && !penable_in;
         end
         default: state_next = crxf_pkg::CRXF_IDLE;
      endcase
      // error and read data are taken at the setup edge, shown in the access cycle
      if (setup_ph) begin
         pslverr_next = !addr_ok;
         if (!pwrite_in) begin
            prdata_next = rdata_comb;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg   <= crxf_pkg::CRXF_IDLE;
         pready_out  <= 1'b0;
         prdata_out  <= '0;
         pslverr_out <= 1'b0;
      end else begin
         state_reg   <= state_next;
         pready_out  <= pready_next;
         prdata_out  <= prdata_next;
         pslverr_out <= pslverr_next;
      end
   end

   // read data is formed combinationally from the live state
   always_comb begin
      rdata_comb = '0;
      case (paddr_in)
         `CRXF_OFS_DONE:     rdata_comb[NBUF-1:0] = rmw_reg ? '1 : done_flags;
         `CRXF_OFS_REMOTE:   rdata_comb[NBUF-1:0] = rmw_reg ? '1 : remote_flags;
         `CRXF_OFS_OVERRUN:  rdata_comb[NBUF-1:0] = rmw_reg ? '1 : overrun_flags;
         `CRXF_OFS_IRQ_EN:   rdata_comb[NBUF-1:0] = irq_en_reg;
         `CRXF_OFS_RMW_CTRL: rdata_comb[`CRXF_RMW_BIT] = rmw_reg;
         `CRXF_OFS_STATUS:   rdata_comb[NBUF-1:0] = done_flags & irq_en_reg;
         `CRXF_OFS_IRQ_STAT: rdata_comb[`CRXF_EVT_W-1:0] = evt_stat_reg;
         `CRXF_OFS_IRQ_ENA:  rdata_comb[`CRXF_EVT_W-1:0] = evt_en_reg;
         default:            rdata_comb = '0;
      endcase
   end

   // flags as they will stand after this edge drive the interrupt, so the
   // line moves on the same edge as the flag and never lags a clear
   logic [NBUF-1:0] done_after;
   always_comb begin
      done_after   = (done_flags & ~done_clr) | rx_store_in;
      rx_irq_next  = |(done_after & irq_en_next);
      evt_irq_next = |(evt_stat_next & evt_en_next);
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_irq_out  <= 1'b0;
         evt_irq_out <= 1'b0;
      end else begin
         rx_irq_out  <= rx_irq_next;
         evt_irq_out <= evt_irq_next;
      end
   end
endmodule
`default_nettype wire
